/* bench/bag_core_sva.sv */
// Checker bound to the ports of the address generator.
// Assumes one clock and the asynchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none
module bag_core_sva
    import bag_pkg::*;
#(
    parameter logic [15:0] TABLE_BASE = 16'h0080,
    parameter logic [4:0]  CALL_PAGE  = 5'h01
) (
    // Clock, reset and requests
    input wire logic        I_CLK,
    input wire logic        I_RST,
    input wire logic        i_fetch,
    input wire logic        i_br_go,
    input wire logic [2:0]  i_br_cmd,
    input wire logic [7:0]  i_opc1,
    input wire logic [7:0]  i_opc2,
    input wire logic [15:0] i_pair_one,
    input wire logic [15:0] i_pair_two,
    input wire logic [15:0] i_pair_three,
    input wire logic [7:0]  i_tbl_data,
    input wire logic        i_tbl_valid,
    input wire logic        i_ind_go,
    input wire logic [1:0]  i_ind_class,
    input wire logic [3:0]  i_ind_spec,
    input wire logic [7:0]  i_ind_disp,
    // Answers
    input wire logic [15:0] O_PC,
    input wire logic        O_BUSY,
    input wire logic [15:0] O_TBL_ADDR,
    input wire logic        O_TBL_RD,
    input wire logic [15:0] O_OPND_ADDR,
    input wire logic        O_WB_EN,
    input wire logic [2:0]  O_WB_SEL,
    input wire logic [15:0] O_WB_DATA
);
    // ****************************************
    // Table byte tracking
    // ****************************************
    logic       go_ok;
    logic       lo_seen_q;
    logic [7:0] lo_q;
    assign go_ok = i_br_go && !O_BUSY;
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            lo_seen_q <= 1'b0;
            lo_q      <= 8'h00;
        end else if (!O_BUSY) begin
            lo_seen_q <= 1'b0;
        end else if (i_tbl_valid) begin
            lo_seen_q <= !lo_seen_q;
            lo_q      <= lo_seen_q ? lo_q : i_tbl_data;
        end
    end
    // ****************************************
    // Properties
    // ****************************************
    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (I_RST);
    a_fetch_step: assert property (
        i_fetch && !i_br_go && !O_BUSY |=> O_PC == $past(O_PC) + 16'h0001)
        else $error("Fetch did not step the counter");
    a_pair_jump: assert property (
        go_ok && i_br_cmd == BR_VIA_PAIR |=> O_PC == $past(i_pair_one))
        else $error("Pair jump target wrong");
    a_page_call: assert property (
        go_ok && i_br_cmd == BR_SHORT_PAGE
        |=> O_PC == {CALL_PAGE, $past(i_opc1[2:0]), $past(i_opc2)})
        else $error("Page call target wrong");
    a_short_rel: assert property (
        go_ok && i_br_cmd == BR_SHORT_REL
        |=> O_PC == $past(O_PC) + {{10{$past(i_opc1[5])}}, $past(i_opc1[5:0])})
        else $error("Short relative target wrong");
    a_long_rel: assert property (
        go_ok && i_br_cmd == BR_LONG_REL
        |=> O_PC == $past(O_PC) + {{8{$past(i_opc1[0])}}, $past(i_opc2)})
        else $error("Long relative target wrong");
    a_table_first: assert property (
        go_ok && i_br_cmd == BR_DIRECT
        |=> O_TBL_RD && O_BUSY && O_TBL_ADDR == TABLE_BASE + {$past(i_opc1[4:0]), 1'b0})
        else $error("First table read wrong");
    a_table_load: assert property (
        O_BUSY && i_tbl_valid && lo_seen_q |=> !O_BUSY && O_PC == {$past(i_tbl_data), lo_q})
        else $error("Table target not loaded");
    a_inc_step: assert property (
        i_ind_go && i_ind_class == IC_BYTE && i_ind_spec == 4'h3 |-> ##2 O_WB_EN
        && O_WB_SEL == PR_TWO && O_WB_DATA == $past(i_pair_two, 2) + STEP_ONE)
        else $error("Post increment wrong");
    a_dbl_step: assert property (
        i_ind_go && i_ind_class == IC_WORD && i_ind_spec == 4'h3 |-> ##2 O_WB_EN
        && O_WB_SEL == PR_THR && O_WB_DATA == $past(i_pair_three, 2) + STEP_TWO)
        else $error("Double increment wrong");
    a_disp_zext: assert property (
        i_ind_go && i_ind_class == IC_BYTE && i_ind_spec == 4'h7
        |=> O_OPND_ADDR == $past(i_pair_two) + {8'h00, $past(i_ind_disp)})
        else $error("Displacement address wrong");
    c_direct: cover property (O_BUSY && i_tbl_valid && lo_seen_q);
    c_page: cover property (go_ok && i_br_cmd == BR_SHORT_PAGE);
    c_wback: cover property (O_WB_EN && O_WB_SEL == PR_THR);
endmodule
bind bag_core bag_core_sva #(.TABLE_BASE(TABLE_BASE), .CALL_PAGE(CALL_PAGE)) u_sva (.*);
`default_nettype wire

/* bench/bag_mem_model.sv */
// Memory partner that answers the branch table reads of the core.
// Assumes read pulses on the core clock; contents fixed at time zero.
`timescale 1ns/10ps
`default_nettype none
module bag_mem_model (
    // Clock and pacing
    input  wire logic        i_clk,
    input  wire logic        i_slow,
    // Table read
    input  wire logic        i_rd,
    input  wire logic [15:0] i_addr,
    output var  logic        o_valid,
    output var  logic [7:0]  o_data
);
    logic [7:0] mem [256];
    logic [7:0] addr_q = 8'h00;
    logic [1:0] wait_q = 2'h0;
    logic       pend_q = 1'b0;
    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = 8'(i * 37 + 11);
        end
        o_valid = 1'b0;
        o_data  = 8'h00;
    end
    // Idle bus shows the inverse so a stale byte never passes
    always @(posedge i_clk) begin
        o_valid <= 1'b0;
        o_data  <= ~o_data;
        if (pend_q && wait_q == 2'h0) begin
            o_valid <= 1'b1;
            o_data  <= mem[addr_q];
            pend_q  <= 1'b0;
        end else if (pend_q) begin
            wait_q <= wait_q - 2'h1;
        end
        if (i_rd) begin
            pend_q <= 1'b1;
            addr_q <= i_addr[7:0];
            wait_q <= i_slow ? 2'h2 : 2'h0;
        end
    end
endmodule
`default_nettype wire

/* bench/tb_branch_and_operand_address_gen.sv */
// Self-checking bench of the address generator against a bench model.
// Assumes bag_pkg, bag_core, bag_mem_model and the bound checker.
`timescale 1ns/10ps
`default_nettype none
module tb_branch_and_operand_address_gen;
    import bag_pkg::*;
    // ****************************************
    // Signals
    // ****************************************
    localparam logic [15:0] TB_BASE = 16'h0080;
    localparam logic [4:0]  TB_PAGE = 5'h03;
    localparam logic [7:0]  BT [12] = '{8'h10, 8'h20, 8'h30, 8'h21, 8'h31, 8'h22, 8'h32,
                                       8'h24, 8'h35, 8'h36, 8'h37, 8'h34};
    localparam logic [7:0]  WT [9]  = '{8'h20, 8'h30, 8'h23, 8'h33, 8'h24, 8'h35, 8'h36,
                                       8'h37, 8'h34};
    logic        I_CLK = 1'b0, I_RST = 1'b1, slow = 1'b0;
    logic        i_fetch = 1'b0, i_br_go = 1'b0, i_reg_go = 1'b0, i_ind_go = 1'b0;
    logic [2:0]  i_br_cmd = 3'h7;
    logic [7:0]  i_opc1 = 8'h00, i_opc2 = 8'h00, i_opc3 = 8'h00, i_ind_disp = 8'h00;
    logic [7:0]  i_acc = 8'h00, i_breg = 8'h00;
    logic [15:0] i_sp = 16'h0000, i_pair_one = 16'h0000, i_pair_two = 16'h0000;
    logic [15:0] i_pair_three = 16'h0000, i_wide_acc = 16'h0000;
    logic [3:0]  i_reg_class = 4'h0, i_ind_spec = 4'h0;
    logic [5:0]  i_reg_spec = 6'h00;
    logic [1:0]  i_ind_class = 2'h0;
    wire logic        i_tbl_valid, O_BUSY, O_TBL_RD, O_REG_VALID, O_REG_ERR;
    wire logic        O_OPND_VALID, O_OPND_ERR, O_WB_EN;
    wire logic [7:0]  i_tbl_data;
    wire logic [15:0] O_PC, O_TBL_ADDR, O_OPND_ADDR, O_WB_DATA;
    wire logic [1:0]  O_REG_KIND;
    wire logic [5:0]  O_REG_ID;
    wire logic [2:0]  O_WB_SEL;
    int err_total = 0, n_compared = 0, seed = 39528, pc_m = 0;

    bag_core #(.TABLE_BASE(TB_BASE), .CALL_PAGE(TB_PAGE)) u_dut (.*);
    bag_mem_model u_mem (.i_clk(I_CLK), .i_slow(slow), .i_rd(O_TBL_RD), .i_addr(O_TBL_ADDR),
                         .o_valid(i_tbl_valid), .o_data(i_tbl_data));
    always #4 I_CLK = ~I_CLK;
    // ****************************************
    // Tasks and model
    // ****************************************
    task automatic tick;
        @(posedge I_CLK);
        #1;
    endtask
    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp, input string m);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH at %0t: %s got %h expected %h", $time, m, got, exp);
        end
    endtask
    task automatic conclude;
        $display("Counts: %0d compared, %0d mismatched", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic fetch(input int n);
        i_fetch = 1'b1;
        repeat (n) tick();
        i_fetch = 1'b0;
        pc_m = (pc_m + n) & 32'hffff;
        chk_val(O_PC, pc_m[15:0], "fetch");
    endtask
    // Fetch is held high over a direct branch: it must be ignored
    task automatic branch(input bag_br_e cmd, input int exp);
        int n;
        i_br_cmd = cmd;
        i_br_go = 1'b1;
        i_fetch = (cmd != BR_NONE);
        tick();
        i_br_go = 1'b0;
        i_fetch = (cmd == BR_DIRECT);
        n = 0;
        while (O_BUSY !== 1'b0) begin
            n++;
            if (n > 20) begin
                err_total++;
                conclude();
            end
            tick();
        end
        i_fetch = 1'b0;
        pc_m = exp & 32'hffff;
        chk_val(O_PC, pc_m[15:0], "branch");
    endtask
    function automatic int exp_id(input int c, input int s);
        case (c)
            0: return s < 8 ? s : -1;
            1: return s < 2 ? 8 + s : s < 8 ? s : -1;
            2: return s < 3 ? s + 1 : -1;
            3: return s < 23 ? s : -1;
            4: return s < 9 ? s : s < 11 ? 2 * s - 8 : s < 16 ? s + 12 : -1;
            5: return s < 9 ? s : s < 11 ? 2 * s - 8 : -1;
            6: return s < 2 ? s + 28 : -1;
            7: return s < 2 ? s + 30 : -1;
            8: return s < 4 ? s : -1;
            9: return s == 0 ? 4 : s < 4 ? s : s == 4 ? 5 : -1;
            10: return s < 4 ? s : s == 4 ? 5 : -1;
            11: return s < 3 ? s + 1 : -1;
            default: return s < 18 ? s : -1;
        endcase
    endfunction
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        logic [15:0] r, a, w;
        logic [7:0]  e;
        int          d, lim;
        repeat (20) @(posedge I_CLK);
        #1;
        I_RST = 1'b0;
        chk_val(O_PC, 16'h0000, "reset");
        for (int k = 0; k < 8; k++) begin
            fetch(1 + k % 4);
            i_pair_one = 16'($random(seed));
            i_wide_acc = 16'($random(seed));
            branch(BR_VIA_PAIR, i_pair_one);
            branch(BR_VIA_WACC, i_wide_acc);
            branch(BR_NONE, pc_m);
            {i_opc1, i_opc2, i_opc3} = 24'($random(seed));
            branch(BR_ABSOLUTE, {i_opc3, i_opc2});
            branch(BR_SHORT_PAGE, {TB_PAGE, i_opc1[2:0], i_opc2});
            if (k < 2) i_opc1 = k ? 8'hdf : 8'h20;
            d = i_opc1[5:0];
            branch(BR_SHORT_REL, pc_m + d - (i_opc1[5] ? 64 : 0));
            fetch(2);
            if (k < 2) {i_opc1, i_opc2} = k ? 16'hfeff : 16'h0100;
            d = {i_opc1[0], i_opc2};
            branch(BR_LONG_REL, pc_m + d - (i_opc1[0] ? 512 : 0));
            slow = k[0];
            i_opc1 = 8'($random(seed));
            d = TB_BASE + 2 * i_opc1[4:0];
            branch(BR_DIRECT, {u_mem.mem[d[7:0] + 1], u_mem.mem[d[7:0]]});
        end
        $display("Test branch done");
        for (int c = 0; c < 13; c++) begin
            for (int s = 0; s < 34; s++) begin
                i_reg_class = 4'(c);
                i_reg_spec = 6'(s);
                i_reg_go = 1'b1;
                tick();
                i_reg_go = 1'b0;
                d = exp_id(c, s);
                lim = c < 3 ? 0 : c < 8 ? 1 : c < 12 ? 2 : 3;
                chk_val({O_REG_VALID, O_REG_ERR}, d < 0 ? 1 : 2, "answer");
                if (d >= 0) chk_val({O_REG_KIND, O_REG_ID}, 16'(d + 64 * lim), "id");
                tick();
            end
        end
        $display("Test register done");
        for (int k = 0; k < 128; k++) begin
            {i_pair_one, i_pair_two} = 32'($random(seed));
            {i_pair_three, i_wide_acc} = 32'($random(seed));
            {i_acc, i_breg, i_ind_disp} = 24'($random(seed) | 32'h808080);
            d = k % 16;
            i_ind_class = 2'(k / 32);
            i_ind_spec = 4'(d);
            i_ind_go = 1'b1;
            tick();
            i_ind_go = 1'b0;
            lim = k < 32 ? 7 : k < 64 ? 3 : k < 96 ? 12 : 9;
            e = d >= lim ? 8'h00 : k < 96 ? BT[d] : WT[d];
            chk_val({O_OPND_VALID, O_OPND_ERR}, e ? 2 : 1, "refuse");
            r = e[5:4] == 2'h1 ? i_pair_one : e[5:4] == 2'h2 ? i_pair_two : i_pair_three;
            case (e[2:0])
                3'h4: a = r + i_ind_disp;
                3'h5: a = r + i_acc;
                3'h6: a = r + i_breg;
                3'h7: a = r + i_wide_acc;
                default: a = r;
            endcase
            if (e) chk_val(O_OPND_ADDR, a, "address");
            w = e[2:0] == 3'h1 ? r + 16'h0001 : e[2:0] == 3'h2 ? r - 16'h0001 : r + 16'h0002;
            tick();
            chk_val(O_WB_EN, e[2:0] inside {3'h1, 3'h2, 3'h3}, "wb");
            if (O_WB_EN === 1'b1) chk_val({O_WB_SEL, O_WB_DATA[12:0]}, {e[6:4], w[12:0]}, "wbd");
        end
        $display("Test indirect done");
        conclude();
    end
endmodule
`default_nettype wire

/* hdl/bag_core.sv */
// Program counter and operand address generation of the core.
// Assumes decoder, pair values and table reads are all on I_CLK.
`timescale 1ns/10ps
`default_nettype none

module bag_core
    import bag_pkg::*;
#(
    parameter logic [15:0] TABLE_BASE = 16'h0080,
    parameter logic [4:0]  CALL_PAGE  = 5'h01
) (
    // Clock and reset
    input  wire logic        I_CLK,
    input  wire logic        I_RST,
    // Fetch and branch requests
    input  wire logic        i_fetch,
    input  wire logic        i_br_go,
    input  wire logic [2:0]  i_br_cmd,
    input  wire logic [7:0]  i_opc1,
    input  wire logic [7:0]  i_opc2,
    input  wire logic [7:0]  i_opc3,
    // Register values
    input  wire logic [15:0] i_sp,
    input  wire logic [15:0] i_pair_one,
    input  wire logic [15:0] i_pair_two,
    input  wire logic [15:0] i_pair_three,
    input  wire logic [15:0] i_wide_acc,
    input  wire logic [7:0]  i_acc,
    input  wire logic [7:0]  i_breg,
    // Branch table read
    input  wire logic [7:0]  i_tbl_data,
    input  wire logic        i_tbl_valid,
    // Register operand request
    input  wire logic        i_reg_go,
    input  wire logic [3:0]  i_reg_class,
    input  wire logic [5:0]  i_reg_spec,
    // Indirect operand request
    input  wire logic        i_ind_go,
    input  wire logic [1:0]  i_ind_class,
    input  wire logic [3:0]  i_ind_spec,
    input  wire logic [7:0]  i_ind_disp,
    // Program counter and branch table read
    output logic [15:0]      O_PC,
    output logic             O_BUSY,
    output logic [15:0]      O_TBL_ADDR,
    output logic             O_TBL_RD,
    // Register operand answer
    output logic             O_REG_VALID,
    output logic             O_REG_ERR,
    output logic [1:0]       O_REG_KIND,
    output logic [5:0]       O_REG_ID,
    // Indirect operand answer
    output logic             O_OPND_VALID,
    output logic             O_OPND_ERR,
    output logic [15:0]      O_OPND_ADDR,
    output logic             O_WB_EN,
    output logic [2:0]       O_WB_SEL,
    output logic [15:0]      O_WB_DATA
);

    // ****************************************
    // Functions
    // ****************************************

    function automatic logic [15:0] sext(input logic [8:0] v, input logic [3:0] sb);
        logic [15:0] r;
        r = 16'h0000;
        for (int k = 0; k < 16; k++) begin
            r[k] = (k <= int'(sb)) ? v[k > 8 ? 8 : k] : v[sb];
        end
        return r;
    endfunction

    // {legal, kind, id}
    function automatic logic [8:0] reg_map(input logic [3:0] c, input logic [5:0] s);
        logic       ok;
        logic [1:0] kd;
        logic [5:0] id;
        ok = 1'b0;
        kd = KIND_REG8;
        id = s;
        case (c)
            CL_R: begin
                ok = (s < 6'h08);
            end
            CL_R1: begin
                ok = (s < 6'h08);
                if (s < 6'h02) begin
                    id = R8_EAH + s;
                end
            end
            CL_R2: begin
                ok = (s < 6'h03);
                id = R8_A + s;
            end
            CL_SR: begin
                ok = (s < SR_CNT);
                kd = KIND_SPEC;
            end
            CL_SR1, CL_SR2: begin
                kd = KIND_SPEC;
                ok = (s < ((c == CL_SR1) ? SR1_CNT : SR2_CNT));
                if (s == SR_SHARE) begin
                    id = SR_EOM;
                end else if (s == SR_SHARE + 6'h01) begin
                    id = SR_TMM;
                end else if (s > SR_SHARE) begin
                    id = SR_RXB + s - SR2_CNT;
                end
            end
            CL_SR3, CL_SR4: begin
                kd = KIND_SPEC;
                ok = (s < 6'h02);
                id = ((c == CL_SR3) ? SR_ETM0 : SR_ECNT) + s;
            end
            CL_RP, CL_RP2: begin
                kd = KIND_PAIR;
                ok = (s < ((c == CL_RP) ? 6'h04 : 6'h05));
                if (s == 6'h04) begin
                    id = {3'h0, PR_WACC};
                end
            end
            CL_RP1: begin
                kd = KIND_PAIR;
                ok = (s < 6'h05);
                if (s == 6'h00) begin
                    id = {3'h0, PR_VA};
                end else if (s == 6'h04) begin
                    id = {3'h0, PR_WACC};
                end
            end
            CL_RP3: begin
                kd = KIND_PAIR;
                ok = (s < 6'h03);
                id = s + 6'h01;
            end
            CL_IRF: begin
                kd = KIND_FLAG;
                ok = (s < IRF_CNT);
            end
            default: begin
                ok = 1'b0;
            end
        endcase
        return {ok, kd, id};
    endfunction

    // {legal, base pair, mode}
    function automatic logic [6:0] ind_map(input logic [1:0] c, input logic [3:0] s);
        logic       ok;
        logic [2:0] bp;
        logic [2:0] md;
        ok = 1'b1;
        bp = PR_THR;
        md = AM_PLAIN;
        if (c == IC_WORD) begin
            case (s)
                4'h0: bp = PR_TWO;
                4'h1: bp = PR_THR;
                4'h2: {bp, md} = {PR_TWO, AM_INC2};
                4'h3: md = AM_INC2;
                4'h4: {bp, md} = {PR_TWO, AM_DISP};
                4'h5: md = AM_IDXA;
                4'h6: md = AM_IDXB;
                4'h7: md = AM_IDXW;
                4'h8: md = AM_DISP;
                default: ok = 1'b0;
            endcase
        end else begin
            case (s)
                4'h0: bp = PR_ONE;
                4'h1: bp = PR_TWO;
                4'h2: bp = PR_THR;
                4'h3: {bp, md} = {PR_TWO, AM_INC};
                4'h4: md = AM_INC;
                4'h5: {bp, md} = {PR_TWO, AM_DEC};
                4'h6: md = AM_DEC;
                4'h7: {bp, md} = {PR_TWO, AM_DISP};
                4'h8: md = AM_IDXA;
                4'h9: md = AM_IDXB;
                4'ha: md = AM_IDXW;
                4'hb: md = AM_DISP;
                default: ok = 1'b0;
            endcase
            if (c == IC_NARROW && s > 4'h2) begin
                ok = 1'b0;
            end
            if (c == IC_PLAIN && s > 4'h6) begin
                ok = 1'b0;
            end
        end
        return {ok, bp, md};
    endfunction

    // ****************************************
    // Branch target
    // ****************************************

    logic [15:0] br_tgt;
    always_comb begin
        br_tgt = O_PC;
        case (bag_br_e'(i_br_cmd))
            BR_VIA_PAIR:   br_tgt = i_pair_one;
            BR_VIA_WACC:   br_tgt = i_wide_acc;
            BR_ABSOLUTE:   br_tgt = {i_opc3, i_opc2};
            BR_SHORT_PAGE: br_tgt = {CALL_PAGE, i_opc1[2:0], i_opc2};
            BR_SHORT_REL:  br_tgt = O_PC + sext({3'h0, i_opc1[5:0]}, 4'h5);
            BR_LONG_REL:   br_tgt = O_PC + sext({i_opc1[0], i_opc2}, 4'h8);
            default:       br_tgt = O_PC;
        endcase
    end

    // ****************************************
    // Direct branch sequencer
    // ****************************************

    // Counter held while the table is read, so no fetch may slip in
    bag_ds_e    ds_q;
    logic [7:0] lo_q;
    logic       dir_go;
    assign dir_go = i_br_go && (bag_br_e'(i_br_cmd) == BR_DIRECT) && (ds_q == DS_IDLE);

    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            ds_q       <= DS_IDLE;
            lo_q       <= 8'h00;
            O_TBL_ADDR <= 16'h0000;
            O_TBL_RD   <= 1'b0;
        end else begin
            O_TBL_RD <= 1'b0;
            case (ds_q)
                DS_IDLE: begin
                    if (dir_go) begin
                        O_TBL_ADDR <= TABLE_BASE + {10'h000, i_opc1[4:0], 1'b0};
                        O_TBL_RD   <= 1'b1;
                        ds_q       <= DS_LOW;
                    end
                end
                DS_LOW: begin
                    if (i_tbl_valid) begin
                        lo_q       <= i_tbl_data;
                        O_TBL_ADDR <= O_TBL_ADDR + STEP_ONE;
                        O_TBL_RD   <= 1'b1;
                        ds_q       <= DS_HIGH;
                    end
                end
                DS_HIGH: begin
                    if (i_tbl_valid) begin
                        ds_q <= DS_IDLE;
                    end
                end
                default: ds_q <= DS_IDLE;
            endcase
        end
    end

    // ****************************************
    // Program counter
    // ****************************************

    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            O_PC   <= PC_RESET;
            O_BUSY <= 1'b0;
        end else begin
            O_BUSY <= (ds_q != DS_IDLE && !(ds_q == DS_HIGH && i_tbl_valid)) || dir_go;
            if (ds_q == DS_HIGH && i_tbl_valid) begin
                O_PC <= {i_tbl_data, lo_q};
            end else if (ds_q != DS_IDLE || dir_go) begin
                O_PC <= O_PC;
            end else if (i_br_go && bag_br_e'(i_br_cmd) != BR_NONE) begin
                O_PC <= br_tgt;
            end else if (i_fetch) begin
                O_PC <= O_PC + STEP_ONE;
            end
        end
    end

    // ****************************************
    // Register operand select
    // ****************************************

    logic [8:0] rmap;
    assign rmap = reg_map(i_reg_class, i_reg_spec);

    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            O_REG_VALID <= 1'b0;
            O_REG_ERR   <= 1'b0;
            O_REG_KIND  <= KIND_REG8;
            O_REG_ID    <= R8_V;
        end else begin
            O_REG_VALID <= i_reg_go && rmap[8];
            O_REG_ERR   <= i_reg_go && !rmap[8];
            if (i_reg_go) begin
                O_REG_KIND <= rmap[7:6];
                O_REG_ID   <= rmap[5:0];
            end
        end
    end

    // ****************************************
    // Indirect operand address
    // ****************************************

    // Write-back lags the address by one cycle so the access uses the old pair
    logic [6:0]  imap;
    logic [15:0] ibase;
    logic [15:0] iofs;
    logic        wb_pend_q;
    logic [2:0]  wb_sel_q;
    logic [15:0] wb_val_q;
    assign imap = ind_map(i_ind_class, i_ind_spec);

    always_comb begin
        case (imap[5:3])
            PR_ONE:  ibase = i_pair_one;
            PR_TWO:  ibase = i_pair_two;
            default: ibase = i_pair_three;
        endcase
        case (bag_am_e'(imap[2:0]))
            AM_DISP: iofs = {8'h00, i_ind_disp};
            AM_IDXA: iofs = {8'h00, i_acc};
            AM_IDXB: iofs = {8'h00, i_breg};
            AM_IDXW: iofs = i_wide_acc;
            default: iofs = 16'h0000;
        endcase
    end

    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            O_OPND_VALID <= 1'b0;
            O_OPND_ERR   <= 1'b0;
            O_OPND_ADDR  <= 16'h0000;
            wb_pend_q    <= 1'b0;
            wb_sel_q     <= PR_SP;
            wb_val_q     <= 16'h0000;
        end else begin
            O_OPND_VALID <= i_ind_go && imap[6];
            O_OPND_ERR   <= i_ind_go && !imap[6];
            wb_pend_q    <= 1'b0;
            if (i_ind_go && imap[6]) begin
                O_OPND_ADDR <= ibase + iofs;
                wb_sel_q    <= imap[5:3];
                case (bag_am_e'(imap[2:0]))
                    AM_INC: begin
                        wb_pend_q <= 1'b1;
                        wb_val_q  <= ibase + STEP_ONE;
                    end
                    AM_DEC: begin
                        wb_pend_q <= 1'b1;
                        wb_val_q  <= ibase - STEP_ONE;
                    end
                    AM_INC2: begin
                        wb_pend_q <= 1'b1;
                        wb_val_q  <= ibase + STEP_TWO;
                    end
                    default: wb_val_q <= ibase;
                endcase
            end
        end
    end

    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            O_WB_EN   <= 1'b0;
            O_WB_SEL  <= PR_SP;
            O_WB_DATA <= 16'h0000;
        end else begin
            O_WB_EN <= wb_pend_q;
            if (wb_pend_q) begin
                O_WB_SEL  <= wb_sel_q;
                O_WB_DATA <= wb_val_q;
            end
        end
    end

endmodule

`default_nettype wire

/* include/bag_pkg.sv */
// Shared constants and types of the branch and operand address generator.
// Assumes a 16-bit program counter and 16-bit register pairs.
package bag_pkg;

    // ****************************************
    // Branch commands
    // ****************************************
    typedef enum logic [2:0] {
        BR_VIA_PAIR   = 3'b000,
        BR_VIA_WACC   = 3'b001,
        BR_ABSOLUTE   = 3'b010,
        BR_SHORT_PAGE = 3'b011,
        BR_DIRECT     = 3'b100,
        BR_SHORT_REL  = 3'b101,
        BR_LONG_REL   = 3'b110,
        BR_NONE       = 3'b111
    } bag_br_e;

    // ****************************************
    // Operand classes
    // ****************************************
    typedef enum logic [3:0] {
        CL_R   = 4'h0, CL_R1  = 4'h1, CL_R2  = 4'h2,
        CL_SR  = 4'h3, CL_SR1 = 4'h4, CL_SR2 = 4'h5,
        CL_SR3 = 4'h6, CL_SR4 = 4'h7,
        CL_RP  = 4'h8, CL_RP1 = 4'h9, CL_RP2 = 4'ha,
        CL_RP3 = 4'hb, CL_IRF = 4'hc
    } bag_cls_e;

    typedef enum logic [1:0] {
        IC_PLAIN = 2'b00,
        IC_NARROW = 2'b01,
        IC_BYTE = 2'b10,
        IC_WORD = 2'b11
    } bag_icls_e;

    // Kind of selected operand
    localparam logic [1:0] KIND_REG8  = 2'h0;
    localparam logic [1:0] KIND_SPEC  = 2'h1;
    localparam logic [1:0] KIND_PAIR  = 2'h2;
    localparam logic [1:0] KIND_FLAG  = 2'h3;

    // Pair identifiers
    localparam logic [2:0] PR_SP   = 3'h0;
    localparam logic [2:0] PR_ONE  = 3'h1;
    localparam logic [2:0] PR_TWO  = 3'h2;
    localparam logic [2:0] PR_THR  = 3'h3;
    localparam logic [2:0] PR_VA   = 3'h4;
    localparam logic [2:0] PR_WACC = 3'h5;

    // Byte register identifiers
    localparam logic [5:0] R8_V    = 6'h00;
    localparam logic [5:0] R8_A    = 6'h01;
    localparam logic [5:0] R8_EAH  = 6'h08;

    // Special register layout in the unified list
    localparam logic [5:0] SR_CNT   = 6'h17;
    localparam logic [5:0] SR2_CNT  = 6'h0b;
    localparam logic [5:0] SR1_CNT  = 6'h10;
    localparam logic [5:0] SR_SHARE = 6'h09;
    localparam logic [5:0] SR_EOM   = 6'h0a;
    localparam logic [5:0] SR_TMM   = 6'h0c;
    localparam logic [5:0] SR_RXB   = 6'h17;
    localparam logic [5:0] SR_ETM0  = 6'h1c;
    localparam logic [5:0] SR_ECNT  = 6'h1e;
    localparam logic [5:0] IRF_CNT  = 6'h12;

    // Indirect modes
    typedef enum logic [2:0] {
        AM_PLAIN = 3'b000, AM_INC  = 3'b001, AM_DEC  = 3'b010,
        AM_INC2  = 3'b011, AM_DISP = 3'b100, AM_IDXA = 3'b101,
        AM_IDXB  = 3'b110, AM_IDXW = 3'b111
    } bag_am_e;

    localparam logic [15:0] STEP_ONE = 16'h0001;
    localparam logic [15:0] STEP_TWO = 16'h0002;
    localparam logic [15:0] PC_RESET = 16'h0000;

    // Direct branch sequencer
    typedef enum logic [1:0] {
        DS_IDLE = 2'b00,
        DS_LOW  = 2'b01,
        DS_HIGH = 2'b10
    } bag_ds_e;

endpackage
